// *** hwcl_regs.sv ***
// Serial target, host watchdog, configuration lock and protection settings.
// Assumes SCL, SDA and the hot flag are asynchronous pins; SDA is open drain outside.
// Summary of operation
// - Missed keepalive sets the timeout flag and pulls the interrupt low.
// - Timeout select: 00 off, 01 16 ms, 10 128 ms, 11 1024 ms.
// - Unlock register holds an 8-bit key; correct key unlocks configuration.
// - Configuration registers come out of reset locked.
// - Protection bit 7 enables undervoltage auto-rearm from lock.
// - Protection bit 6 enables thermal auto-rearm from lock.
// - With gate bit set, power-up is refused while junction is above 125 C.
// - Pre-warning select: 0 gives 140 C, 1 gives 130 C.
// - Undervoltage select picks threshold pair; codes 1100 to 1111 unavailable.
`include "hwcl_cfg.svh"

module hwcl_regs
    import hwcl_pkg::*;
#(
    parameter logic [6:0]       DEV_ADDR      = 7'h10,  // Arbitrary value
    parameter logic [7:0]       UNLOCK_KEY    = 8'h5A,  // Arbitrary value
    parameter int               CNT_W         = 26,
    parameter logic [CNT_W-1:0] TMO_SHORT_CYC =
        CNT_W'(64'(`HWCL_TMO_SHORT_MS) * 64'(`HWCL_CLK_HZ) / 64'(`HWCL_MS_PER_S)),
    parameter logic [CNT_W-1:0] TMO_MID_CYC   =
        CNT_W'(64'(`HWCL_TMO_MID_MS) * 64'(`HWCL_CLK_HZ) / 64'(`HWCL_MS_PER_S)),
    parameter logic [CNT_W-1:0] TMO_LONG_CYC  =
        CNT_W'(64'(`HWCL_TMO_LONG_MS) * 64'(`HWCL_CLK_HZ) / 64'(`HWCL_MS_PER_S))
)(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    output logic            intN,
    output logic            hostTimeoutFlag,
    output logic            cfgUnlocked,
    output logic            undervoltLockRearm,
    output logic            thermalLockRearm,
    output logic            thermalStartupGate,
    output logic            thermalPrewarnSelect,
    output logic [3:0]      undervoltThresholdSelect,
    input  wire logic       tjOver125,
    input  wire logic       powerUpReq,
    output logic            powerUpAllowed
);

    // Pin synchronisers
    logic sclMeta_r, sclSync_r, sclPrev_r, sdaMeta_r, sdaSync_r, sdaPrev_r, hotMeta_r, hotSync_r;
    logic sclMeta_nxt, sclSync_nxt, sclPrev_nxt, sdaMeta_nxt, sdaSync_nxt, sdaPrev_nxt;
    logic hotMeta_nxt, hotSync_nxt;
    logic sclRise, sclFall, busStart, busStop;

    always_comb begin
        sclMeta_nxt = sclIn;
        sclSync_nxt = sclMeta_r;
        sclPrev_nxt = sclSync_r;
        sdaMeta_nxt = sdaIn;
        sdaSync_nxt = sdaMeta_r;
        sdaPrev_nxt = sdaSync_r;
        hotMeta_nxt = tjOver125;
        hotSync_nxt = hotMeta_r;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sclMeta_r <= 1'b1;
            sclSync_r <= 1'b1;
            sclPrev_r <= 1'b1;
            sdaMeta_r <= 1'b1;
            sdaSync_r <= 1'b1;
            sdaPrev_r <= 1'b1;
            hotMeta_r <= 1'b0;
            hotSync_r <= 1'b0;
        end else begin
            sclMeta_r <= sclMeta_nxt;
            sclSync_r <= sclSync_nxt;
            sclPrev_r <= sclPrev_nxt;
            sdaMeta_r <= sdaMeta_nxt;
            sdaSync_r <= sdaSync_nxt;
            sdaPrev_r <= sdaPrev_nxt;
            hotMeta_r <= hotMeta_nxt;
            hotSync_r <= hotSync_nxt;
        end
    end

    assign sclRise  = sclSync_r & ~sclPrev_r;
    assign sclFall  = ~sclSync_r & sclPrev_r;
    assign busStart = sclSync_r & sclPrev_r & sdaPrev_r & ~sdaSync_r;
    assign busStop  = sclSync_r & sclPrev_r & ~sdaPrev_r & sdaSync_r;

    // Register state
    logic            keepalive_r, keepalive_nxt, unlocked_r, unlocked_nxt;
    logic [7:0]      key_r, key_nxt, prot_r, prot_nxt;
    logic [1:0]      tmoSel_r, tmoSel_nxt;
    logic [7:0]      rdByte;

    // Serial target state
    hwcl_state_t     state_r, state_nxt;
    logic [3:0]      bitCnt_r, bitCnt_nxt;
    logic [7:0]      shift_r, shift_nxt, ptr_r, ptr_nxt;
    logic            rw_r, rw_nxt, oe_r, oe_nxt, mack_r, mack_nxt, wrEn;

    always_comb begin
        case (ptr_r)
            `HWCL_ADDR_KEEPALIVE: rdByte = 8'(keepalive_r);
            `HWCL_ADDR_UNLOCK:    rdByte = key_r;
            `HWCL_ADDR_TMOCFG:    rdByte = 8'(tmoSel_r);
            `HWCL_ADDR_PROTCFG:   rdByte = prot_r;
            default:              rdByte = 8'h00;
        endcase
    end

    always_comb begin
        state_nxt  = state_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt  = shift_r;
        ptr_nxt    = ptr_r;
        rw_nxt     = rw_r;
        oe_nxt     = oe_r;
        mack_nxt   = mack_r;
        wrEn       = 1'b0;
        if (busStop) begin
            state_nxt = ST_IDLE;
            oe_nxt    = 1'b0;
        end else if (busStart) begin
            state_nxt  = ST_ADDR;
            bitCnt_nxt = 4'h0;
            oe_nxt     = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                end
                ST_ADDR, ST_PTR, ST_WR: begin
                    if (sclRise && bitCnt_r != `HWCL_I2C_BITS) begin
                        shift_nxt  = {shift_r[6:0], sdaSync_r};
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == `HWCL_I2C_BITS) begin
                        bitCnt_nxt = 4'h0;
                        oe_nxt     = 1'b1;
                        if (state_r == ST_ADDR) begin
                            if (shift_r[7:1] == DEV_ADDR) begin
                                state_nxt = ST_AACK;
                                rw_nxt    = shift_r[0];
                            end else begin
                                state_nxt = ST_IDLE;
                                oe_nxt    = 1'b0;
                            end
                        end else if (state_r == ST_PTR) begin
                            ptr_nxt   = shift_r;
                            state_nxt = ST_PACK;
                        end else begin
                            wrEn      = 1'b1;
                            state_nxt = ST_WACK;
                        end
                    end
                end
                ST_AACK: begin
                    if (sclFall && rw_r) begin
                        shift_nxt = rdByte;
                        oe_nxt    = ~rdByte[7];
                        state_nxt = ST_RD;
                    end else if (sclFall) begin
                        oe_nxt    = 1'b0;
                        state_nxt = ST_PTR;
                    end
                end
                ST_PACK: begin
                    if (sclFall) begin
                        oe_nxt    = 1'b0;
                        state_nxt = ST_WR;
                    end
                end
                ST_WACK: begin
                    if (sclFall) begin
                        oe_nxt    = 1'b0;
                        ptr_nxt   = ptr_r + 8'h01;
                        state_nxt = ST_WR;
                    end
                end
                ST_RD: begin
                    if (sclFall && bitCnt_r == `HWCL_I2C_BITS - 4'h1) begin
                        oe_nxt     = 1'b0;
                        bitCnt_nxt = 4'h0;
                        ptr_nxt    = ptr_r + 8'h01;
                        state_nxt  = ST_RACK;
                    end else if (sclFall) begin
                        shift_nxt  = {shift_r[6:0], 1'b0};
                        oe_nxt     = ~shift_r[6];
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        mack_nxt = ~sdaSync_r;
                    end else if (sclFall && mack_r) begin
                        shift_nxt = rdByte;
                        oe_nxt    = ~rdByte[7];
                        state_nxt = ST_RD;
                    end else if (sclFall) begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    oe_nxt    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_r  <= ST_IDLE;
            bitCnt_r <= 4'h0;
            shift_r  <= 8'h00;
            ptr_r    <= 8'h00;
            rw_r     <= 1'b0;
            oe_r     <= 1'b0;
            mack_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            bitCnt_r <= bitCnt_nxt;
            shift_r  <= shift_nxt;
            ptr_r    <= ptr_nxt;
            rw_r     <= rw_nxt;
            oe_r     <= oe_nxt;
            mack_r   <= mack_nxt;
        end
    end

    // Register writes and lock
    logic kick, selChg;
    assign kick   = wrEn && ptr_r == `HWCL_ADDR_KEEPALIVE;
    assign selChg = wrEn && ptr_r == `HWCL_ADDR_TMOCFG && unlocked_r;

    always_comb begin
        keepalive_nxt = keepalive_r;
        key_nxt       = key_r;
        unlocked_nxt  = unlocked_r;
        tmoSel_nxt    = tmoSel_r;
        prot_nxt      = prot_r;
        if (wrEn) begin
            case (ptr_r)
                `HWCL_ADDR_KEEPALIVE: keepalive_nxt = shift_r[`HWCL_BIT_KEEPALIVE];
                `HWCL_ADDR_UNLOCK: begin
                    key_nxt      = shift_r;
                    unlocked_nxt = (shift_r == UNLOCK_KEY);
                end
                `HWCL_ADDR_TMOCFG: begin
                    if (unlocked_r) begin
                        tmoSel_nxt = shift_r[`HWCL_TMOSEL_MSB:0];
                    end
                end
                `HWCL_ADDR_PROTCFG: begin
                    if (unlocked_r) begin
                        prot_nxt[`HWCL_BIT_UVREARM:`HWCL_BIT_PREWARN] =
                            shift_r[`HWCL_BIT_UVREARM:`HWCL_BIT_PREWARN];
                        // Unavailable threshold codes are dropped
                        if (shift_r[`HWCL_UVSEL_MSB:0] <= `HWCL_UVSEL_LAST) begin
                            prot_nxt[`HWCL_UVSEL_MSB:0] = shift_r[`HWCL_UVSEL_MSB:0];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            keepalive_r <= `HWCL_RST_KEEPALIVE;
            key_r       <= `HWCL_RST_UNLOCK;
            unlocked_r  <= 1'b0;
            tmoSel_r    <= `HWCL_RST_TMOCFG;
            prot_r      <= `HWCL_RST_PROTCFG;
        end else begin
            keepalive_r <= keepalive_nxt;
            key_r       <= key_nxt;
            unlocked_r  <= unlocked_nxt;
            tmoSel_r    <= tmoSel_nxt;
            prot_r      <= prot_nxt;
        end
    end

    // Host watchdog
    logic [CNT_W-1:0] wdCnt_r, wdCnt_nxt, wdLimit;
    logic             flag_r, flag_nxt, wdOn, wdHit;

    always_comb begin
        case (tmoSel_r)
            `HWCL_TMO_SHORT: wdLimit = TMO_SHORT_CYC;
            `HWCL_TMO_MID:   wdLimit = TMO_MID_CYC;
            `HWCL_TMO_LONG:  wdLimit = TMO_LONG_CYC;
            default:         wdLimit = TMO_SHORT_CYC;
        endcase
        wdOn  = (tmoSel_r != `HWCL_TMO_OFF);
        wdHit = wdOn && !kick && !selChg && (wdCnt_r == wdLimit - CNT_W'(1));
        wdCnt_nxt = (!wdOn || kick || selChg || wdHit) ? '0 : wdCnt_r + CNT_W'(1);
        // A keepalive in the final cycle still counts as in time
        flag_nxt = wdHit ? 1'b1 : (kick ? 1'b0 : flag_r);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wdCnt_r <= '0;
            flag_r  <= 1'b0;
        end else begin
            wdCnt_r <= wdCnt_nxt;
            flag_r  <= flag_nxt;
        end
    end

    // Power-up gating
    logic pwrOk_r, pwrOk_nxt;

    always_comb begin
        pwrOk_nxt = powerUpReq && !(prot_r[`HWCL_BIT_TSDGATE] && hotSync_r);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pwrOk_r <= 1'b0;
        end else begin
            pwrOk_r <= pwrOk_nxt;
        end
    end

    assign sdaOut                   = 1'b0;
    assign sdaOe                    = oe_r;
    assign intN                     = ~flag_r;
    assign hostTimeoutFlag          = flag_r;
    assign cfgUnlocked              = unlocked_r;
    assign undervoltLockRearm       = prot_r[`HWCL_BIT_UVREARM];
    assign thermalLockRearm         = prot_r[`HWCL_BIT_TSDREARM];
    assign thermalStartupGate       = prot_r[`HWCL_BIT_TSDGATE];
    assign thermalPrewarnSelect     = prot_r[`HWCL_BIT_PREWARN];
    assign undervoltThresholdSelect = prot_r[`HWCL_UVSEL_MSB:0];
    assign powerUpAllowed           = pwrOk_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_timeout_flag_int: assert property (wdHit |=> hostTimeoutFlag && !intN ##1 (!intN || $past(kick)))
        else $error("timeout did not flag and pull interrupt");
    a_short_period: assert property ($rose(hostTimeoutFlag) && tmoSel_r == `HWCL_TMO_SHORT
        |-> $past(wdCnt_r) == TMO_SHORT_CYC - CNT_W'(1))
        else $error("wrong short watchdog period");
    a_off_no_flag: assert property (tmoSel_r == `HWCL_TMO_OFF |=> wdCnt_r == '0 && !$rose(flag_r))
        else $error("disabled watchdog counted");
    a_key_unlocks: assert property (wrEn && ptr_r == `HWCL_ADDR_UNLOCK && shift_r == UNLOCK_KEY |=> cfgUnlocked)
        else $error("correct key did not unlock");
    a_reset_locked: assert property ($rose(resetn) |-> !cfgUnlocked)
        else $error("configuration unlocked after reset");
    a_uv_rearm: assert property (wrEn && ptr_r == `HWCL_ADDR_PROTCFG && unlocked_r
        |=> undervoltLockRearm == $past(shift_r[`HWCL_BIT_UVREARM]))
        else $error("undervoltage rearm bit not taken");
    a_thermal_lock_rearm: assert property (wrEn && ptr_r == `HWCL_ADDR_PROTCFG && unlocked_r
        |=> thermalLockRearm == $past(shift_r[`HWCL_BIT_TSDREARM]))
        else $error("thermal rearm bit not taken");
    a_hot_gate: assert property (thermalStartupGate && hotSync_r |=> !powerUpAllowed)
        else $error("power-up allowed while hot and gated");
    a_prewarn_sel: assert property (wrEn && ptr_r == `HWCL_ADDR_PROTCFG && unlocked_r
        |=> thermalPrewarnSelect == $past(shift_r[`HWCL_BIT_PREWARN]))
        else $error("pre-warning select not taken");
    a_uv_code_na: assert property (wrEn && ptr_r == `HWCL_ADDR_PROTCFG && shift_r[`HWCL_UVSEL_MSB:0] > `HWCL_UVSEL_LAST
        |=> $stable(undervoltThresholdSelect))
        else $error("unavailable threshold code stored");
    a_locked_ignore: assert property (wrEn && !unlocked_r && ptr_r == `HWCL_ADDR_TMOCFG |=> $stable(tmoSel_r))
        else $error("locked write changed timeout select");
    a_kick_restart: assert property (kick |=> wdCnt_r == '0
        ##1 (wdCnt_r == CNT_W'(1) || !wdOn || $past(kick || selChg)))
        else $error("keepalive did not restart watchdog");

endmodule : hwcl_regs

// *** hwcl_cfg.svh ***
// Constants of the host watchdog and configuration lock block.
// Assumes an 8-bit register pointer on the serial port.
`ifndef HWCL_CFG_SVH
`define HWCL_CFG_SVH
// Register offsets
`define HWCL_ADDR_KEEPALIVE 8'h12
`define HWCL_ADDR_UNLOCK    8'h13
`define HWCL_ADDR_TMOCFG    8'h14
`define HWCL_ADDR_PROTCFG   8'h15
// Reset values
`define HWCL_RST_KEEPALIVE  1'h0
`define HWCL_RST_UNLOCK     8'h00
`define HWCL_RST_TMOCFG     2'h0
`define HWCL_RST_PROTCFG    8'h25
// Field positions
`define HWCL_BIT_KEEPALIVE  0
`define HWCL_TMOSEL_MSB     1
`define HWCL_BIT_UVREARM    7
`define HWCL_BIT_TSDREARM   6
`define HWCL_BIT_TSDGATE    5
`define HWCL_BIT_PREWARN    4
`define HWCL_UVSEL_MSB      3
`define HWCL_UVSEL_LAST     4'hB
// Timeout select codes
`define HWCL_TMO_OFF        2'h0
`define HWCL_TMO_SHORT      2'h1
`define HWCL_TMO_MID        2'h2
`define HWCL_TMO_LONG       2'h3
// Timing
`define HWCL_CLK_HZ         40000000
`define HWCL_MS_PER_S       1000
`define HWCL_TMO_SHORT_MS   16
`define HWCL_TMO_MID_MS     128
`define HWCL_TMO_LONG_MS    1024
`define HWCL_I2C_BITS       4'h8
`endif

// *** hwcl_pkg.sv ***
// Types of the host watchdog and configuration lock block.
// Assumes nothing of its surroundings.
package hwcl_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_PTR,
        ST_PACK,
        ST_WR,
        ST_WACK,
        ST_RD,
        ST_RACK
    } hwcl_state_t;
endpackage : hwcl_pkg

// *** hwcl_host_model.sv ***
// Serial host model: drives SCL and an open-drain SDA pull-down.
// Assumes a pull-up on SDA; sdaWire is the resolved line level.
module hwcl_host_model (
    input  wire logic core_clk,
    input  wire logic sdaWire,
    output logic      sclOut,
    output logic      sdaDrv
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclOut = 1'b1;
        sdaDrv = 1'b1;
    end

    task automatic waitClk(input int n);
        repeat (n) @(negedge core_clk);
    endtask : waitClk

    // Also serves as repeated start
    task automatic busStart();
        sdaDrv = 1'b1;
        waitClk(8);
        sclOut = 1'b1;
        waitClk(8);
        sdaDrv = 1'b0;
        waitClk(8);
        sclOut = 1'b0;
    endtask : busStart

    task automatic busStop();
        sdaDrv = 1'b0;
        waitClk(8);
        sclOut = 1'b1;
        waitClk(8);
        sdaDrv = 1'b1;
        waitClk(8);
    endtask : busStop

    // SCL low 8 clocks, high 8 clocks, sampled mid-high
    task automatic busBit(input logic b, output logic r);
        waitClk(2);
        sdaDrv = b;
        waitClk(6);
        sclOut = 1'b1;
        waitClk(4);
        r = sdaWire;
        waitClk(4);
        sclOut = 1'b0;
    endtask : busBit

    task automatic sendByte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            busBit(v[i], r);
        end
        busBit(1'b1, r);
        ack = ~r;
    endtask : sendByte

    task automatic recvByte(input logic nack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            busBit(1'b1, v[i]);
        end
        busBit(nack, r);
    endtask : recvByte
endmodule : hwcl_host_model

// *** host_watchdog_config_lock_tb_top.sv ***
// Self-checking bench of the watchdog and configuration lock registers.
// Assumes the serial host model and shortened watchdog limits.
module host_watchdog_config_lock_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] DEV = 7'h10;
    localparam logic [7:0] KEY = 8'h5A;
    localparam int         T1  = 2000;
    localparam int         T2  = 4000;
    localparam int         T3  = 8000;

    logic       core_clk;
    logic       resetn;
    logic       sclIn;
    logic       sdaDrv;
    logic       sdaIn;
    logic       sdaOut;
    logic       sdaOe;
    logic       intN;
    logic       hostTimeoutFlag;
    logic       cfgUnlocked;
    logic       uvR;
    logic       thR;
    logic       gate;
    logic       prew;
    logic [3:0] uvSel;
    logic       tjOver125;
    logic       powerUpReq;
    logic       powerUpAllowed;
    int         bad_count;
    int         cmp_count;
    logic [7:0] d;
    logic       a;
    logic [7:0] vals [5];
    int         lims [4];

    assign sdaIn = sdaDrv & (sdaOe ? sdaOut : 1'b1);

    // Address and key are left at their defaults, which DEV and KEY mirror
    hwcl_regs #(
        .TMO_SHORT_CYC(26'(T1)),
        .TMO_MID_CYC  (26'(T2)),
        .TMO_LONG_CYC (26'(T3))
    ) DUT (
        .core_clk                (core_clk),
        .resetn                  (resetn),
        .sclIn                   (sclIn),
        .sdaIn                   (sdaIn),
        .sdaOut                  (sdaOut),
        .sdaOe                   (sdaOe),
        .intN                    (intN),
        .hostTimeoutFlag         (hostTimeoutFlag),
        .cfgUnlocked             (cfgUnlocked),
        .undervoltLockRearm      (uvR),
        .thermalLockRearm        (thR),
        .thermalStartupGate      (gate),
        .thermalPrewarnSelect    (prew),
        .undervoltThresholdSelect(uvSel),
        .tjOver125               (tjOver125),
        .powerUpReq              (powerUpReq),
        .powerUpAllowed          (powerUpAllowed)
    );

    hwcl_host_model host (
        .core_clk(core_clk),
        .sdaWire (sdaIn),
        .sclOut  (sclIn),
        .sdaDrv  (sdaDrv)
    );

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic regWr(input logic [7:0] ptr, input logic [7:0] data);
        logic ack;
        host.busStart();
        host.sendByte({DEV, 1'b0}, ack);
        check(ack, 8'h01);
        host.sendByte(ptr, ack);
        check(ack, 8'h01);
        host.sendByte(data, ack);
        check(ack, 8'h01);
        host.busStop();
    endtask : regWr

    task automatic regRd(input logic [7:0] ptr, output logic [7:0] v);
        logic ack;
        host.busStart();
        host.sendByte({DEV, 1'b0}, ack);
        host.sendByte(ptr, ack);
        host.busStart();
        host.sendByte({DEV, 1'b1}, ack);
        host.recvByte(1'b1, v);
        host.busStop();
    endtask : regRd

    initial begin
        #(25ns * 90000);
        bad_count++;
        summarize();
    end

    initial begin
        resetn = 1'b0;
        tjOver125 = 1'b0;
        powerUpReq = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        vals = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0B};
        lims = '{0, T1, T2, T3};
        host.waitClk(10);
        resetn = 1'b1;
        host.waitClk(10);
        // Reset state
        for (int i = 0; i < 4; i++) begin
            regRd(8'h12 + 8'(i), d);
            check(d, (i == 3) ? 8'h25 : 8'h00);
        end
        check({intN, hostTimeoutFlag, cfgUnlocked}, 8'h04);
        check({uvR, thR, gate, prew, uvSel}, 8'h25);
        // Locked writes are dropped
        regWr(8'h15, 8'hC3);
        regWr(8'h14, 8'h01);
        regRd(8'h15, d);
        check(d, 8'h25);
        regRd(8'h14, d);
        check(d, 8'h00);
        check(cfgUnlocked, 8'h00);
        // Unmapped pointer and foreign address
        regRd(8'h30, d);
        check(d, 8'h00);
        host.busStart();
        host.sendByte({7'h11, 1'b0}, a);
        check(a, 8'h00);
        host.busStop();
        // Unlock
        regWr(8'h13, KEY);
        check(cfgUnlocked, 8'h01);
        regRd(8'h13, d);
        check(d, KEY);
        // Protection fields
        for (int i = 0; i < 5; i++) begin
            regWr(8'h15, vals[i]);
            check({uvR, thR, gate, prew, uvSel}, vals[i]);
        end
        regWr(8'h15, 8'hFC);
        regRd(8'h15, d);
        check(d, 8'hFB);
        // Two-byte read with master acknowledge, pointer auto-increments
        host.busStart();
        host.sendByte({DEV, 1'b0}, a);
        host.sendByte(8'h14, a);
        host.busStart();
        host.sendByte({DEV, 1'b1}, a);
        host.recvByte(1'b0, d);
        check(d, 8'h00);
        host.recvByte(1'b1, d);
        check(d, 8'hFB);
        host.busStop();
        // Thermal startup gate
        regWr(8'h15, 8'h20);
        powerUpReq = 1'b1;
        tjOver125 = 1'b1;
        host.waitClk(6);
        check(powerUpAllowed, 8'h00);
        tjOver125 = 1'b0;
        host.waitClk(6);
        check(powerUpAllowed, 8'h01);
        regWr(8'h15, 8'h00);
        tjOver125 = 1'b1;
        host.waitClk(6);
        check(powerUpAllowed, 8'h01);
        tjOver125 = 1'b0;
        powerUpReq = 1'b0;
        // Watchdog disabled never flags
        host.waitClk(T3 + 100);
        check(hostTimeoutFlag, 8'h00);
        // Regular keepalive keeps the flag down
        regWr(8'h14, 8'h01);
        for (int i = 0; i < 4; i++) begin
            host.waitClk(T1 / 2);
            regWr(8'h12, 8'h01);
        end
        check(hostTimeoutFlag, 8'h00);
        // Each timeout length
        for (int s = 1; s < 4; s++) begin
            regWr(8'h14, 8'(s));
            host.waitClk(lims[s] - 80);
            check(hostTimeoutFlag, 8'h00);
            for (int k = 0; k < 100 && hostTimeoutFlag !== 1'b1; k++) begin
                host.waitClk(1);
            end
            check(hostTimeoutFlag, 8'h01);
            check(intN, 8'h00);
            regWr(8'h12, 8'h01);
            check({hostTimeoutFlag, intN}, 8'h01);
        end
        summarize();
    end
endmodule : host_watchdog_config_lock_tb_top
